// >>> shared/dlpe_pkg.sv
// Purpose: constants and types shared by the diagnostic lamp encoder
// Assumes: 200 MHz system clock, 32-bit register bus
// Notes:   all blink and flash timing is a multiple of one 0.125 s tick
package dlpe_pkg;
    // clock and timebase
    localparam int CLK_KHZ         = 200000;
    localparam int TICK_MS         = 125;
    localparam int TICK_CYC        = TICK_MS * CLK_KHZ;
    localparam int TICK_CYC_DIV    = 1000;
    localparam int PRE_W           = 25;
    // flash timing: 0.25 s flashes every 2.5 s
    localparam int FLASH_MS        = 250;
    localparam int FLASH_PERIOD_MS = 2500;
    localparam int FLASH_TICKS     = FLASH_MS / TICK_MS;
    localparam int FLASH_PER_TICKS = FLASH_PERIOD_MS / TICK_MS;
    localparam int PH20_W          = 5;
    localparam int PH8_W           = 3;
    // process data activity window of one second
    localparam int ACT_WINDOW_MS   = 1000;
    localparam int ACT_TICKS       = ACT_WINDOW_MS / TICK_MS;
    localparam int ACT_W           = 4;
    // register byte offsets
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_MSW      = 8'h04;
    localparam logic [7:0] REG_LAMP     = 8'h08;
    localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
    localparam logic [7:0] REG_IRQ_MASK = 8'h10;
    // module status word bit positions
    localparam int MSW_W        = 7;
    localparam int MSW_INIT     = 0;
    localparam int MSW_CYCLIC   = 1;
    localparam int MSW_FLASH1   = 2;
    localparam int MSW_FLASH2   = 3;
    localparam int MSW_RED_BLNK = 4;
    localparam int MSW_RED_ON   = 5;
    localparam int MSW_FC_FLASH = 6;
    // control and interrupt fields
    localparam int CTRL_FC_VARIANT = 0;
    localparam int IRQ_W           = 4;
    localparam int IRQ_MOD_FAULT   = 0;
    localparam int IRQ_ACT_LOST    = 1;
    localparam int IRQ_SYS_ERR     = 2;
    localparam int IRQ_BUS_OFF     = 3;
    // reset values
    localparam logic             CTRL_RST = 1'b0;
    localparam logic [IRQ_W-1:0] MASK_RST = 4'h0;
    // lamp field positions in the lamp register
    localparam int LAMP_MOD_PAT = 0;
    localparam int LAMP_MOD_RED = 3;
    localparam int LAMP_ST_PAT  = 4;
    localparam int LAMP_ERR_PAT = 8;

    typedef enum logic [2:0] {
        PAT_OFF,
        PAT_ON,
        PAT_BLINK1,
        PAT_BLINK2,
        PAT_BLINK4,
        PAT_FLASH1,
        PAT_FLASH2
    } dlpe_pat_t;
endpackage

// >>> design/dlpe_timebase.sv
// Purpose: shared blink and flash timebase for all lamps
// Assumes: one tick per TICK_CYC clocks
// Notes:   phase counters advance only on the tick
`timescale 1ns/100ps
module dlpe_timebase #(
    parameter int TICK_CYC = dlpe_pkg::TICK_CYC
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // pattern levels
    output logic      tick,
    output logic      blink1,
    output logic      blink2,
    output logic      blink4,
    output logic      flash1,
    output logic      flash2
);
    localparam logic [dlpe_pkg::PRE_W-1:0] PRE_LAST =
        dlpe_pkg::PRE_W'(TICK_CYC - 1);
    localparam logic [dlpe_pkg::PH20_W-1:0] PH_LAST =
        dlpe_pkg::PH20_W'(dlpe_pkg::FLASH_PER_TICKS - 1);
    localparam logic [dlpe_pkg::PH20_W-1:0] FL_LEN =
        dlpe_pkg::PH20_W'(dlpe_pkg::FLASH_TICKS);

    typedef struct packed {
        logic [dlpe_pkg::PRE_W-1:0]  pre;
        logic [dlpe_pkg::PH8_W-1:0]  ph8;
        logic [dlpe_pkg::PH20_W-1:0] ph20;
    } dlpe_tb_state_t;

    dlpe_tb_state_t st;
    dlpe_tb_state_t next_st;

    // one prescaler drives every phase so all patterns stay in step
    always_comb begin
        next_st = st;
        tick    = (st.pre == PRE_LAST);
        if (tick) begin
            next_st.pre  = '0;
            next_st.ph8  = st.ph8 + 3'h1;
            next_st.ph20 = (st.ph20 == PH_LAST) ? '0 : st.ph20 + 5'h01;
        end else begin
            next_st.pre = st.pre + 25'h0000001;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // 4 Hz toggles every tick, 2 Hz every two, 1 Hz every four
    assign blink4 = st.ph8[0];
    assign blink2 = st.ph8[1];
    assign blink1 = st.ph8[2];
    assign flash1 = (st.ph20 < FL_LEN);
    assign flash2 = (st.ph20 < FL_LEN) ||
                    (st.ph20 >= 2 * FL_LEN && st.ph20 < 3 * FL_LEN);
endmodule

// >>> design/dlpe_act_mon.sv
// Purpose: process data activity watch for the system bus state lamp
// Assumes: telegram is already stripped of service data transfers
// Notes:   active drops after a full window of ticks with no telegram
`timescale 1ns/100ps
module dlpe_act_mon (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // timebase and traffic
    input  wire logic tick,
    input  wire logic telegram,
    // result
    output logic      active
);
    localparam logic [dlpe_pkg::ACT_W-1:0] ACT_LIM =
        dlpe_pkg::ACT_W'(dlpe_pkg::ACT_TICKS);

    typedef struct packed {
        logic [dlpe_pkg::ACT_W-1:0] age;
    } dlpe_act_state_t;

    dlpe_act_state_t st;
    dlpe_act_state_t next_st;

    // age saturates so a long silence never wraps back to active
    always_comb begin
        next_st = st;
        if (telegram) begin
            next_st.age = '0;
        end else if (tick && st.age != ACT_LIM) begin
            next_st.age = st.age + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st.age <= ACT_LIM;
        end else begin
            st <= next_st;
        end
    end

    assign active = (st.age < ACT_LIM);
endmodule

// >>> design/dlpe_encoder.sv
// Purpose: diagnostic lamp pattern encoder with AHB-Lite registers
// Assumes: status inputs synchronous to clk, one AHB-Lite slave
// Notes:   lamps and bus outputs are registered, zero wait states
//
// Functional notes
// - module lamp dark when module absent/unready
// - steady green during cyclic data exchange
// - green 2 Hz when initialised, no exchange
// - single red flash on external timeout
// - double red flash on watchdog/DIP fault
// - controller variant reports flashes in bit 6
// - red 2 Hz on controller, warning, system error
// - steady red on configuration error, bus off
// - state lamp dark idle, 4 Hz on warning
// - state lamp steady while telegrams every second
// - service data transfers are not activity
// - error lamp 4 Hz on monitoring timeout
// - error lamp 1 Hz on external module error
// - error lamp steady while bus off
`timescale 1ns/100ps
module dlpe_encoder #(
    parameter int TICK_CYC = dlpe_pkg::TICK_CYC
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // communication module status
    input  wire logic        modReady,
    input  wire logic        ctrlVoltOk,
    input  wire logic        modFitted,
    input  wire logic        modIsIoExt,
    input  wire logic        modInit,
    input  wire logic        cyclicRun,
    input  wire logic        extTimeout,
    input  wire logic        wdTimeout,
    input  wire logic        dipInvalid,
    input  wire logic        ctrlInaccess,
    input  wire logic        modWarning,
    input  wire logic        busIfErr,
    input  wire logic        cfgError,
    input  wire logic        modBusOff,
    // system bus supervision
    input  wire logic        sysWarning,
    input  wire logic        telegramRx,
    input  wire logic        telegramSdo,
    input  wire logic        tgTimeout,
    input  wire logic        extMonTimeout,
    input  wire logic        extBusTimeout,
    input  wire logic        extModuleErr,
    input  wire logic        sysBusOff,
    // lamps and interrupt
    output logic             modLedGreen,
    output logic             modLedRed,
    output logic             busStateLed,
    output logic             busErrLed,
    output logic             irq
);
    typedef struct packed {
        logic                       ctrlFc;
        logic [dlpe_pkg::IRQ_W-1:0] irqStat;
        logic [dlpe_pkg::IRQ_W-1:0] irqMask;
        logic [dlpe_pkg::MSW_W-1:0] msw;
        dlpe_pkg::dlpe_pat_t        modPat;
        logic                       modRed;
        dlpe_pkg::dlpe_pat_t        statePat;
        dlpe_pkg::dlpe_pat_t        errPat;
        logic                       prevActive;
        logic                       dpValid;
        logic                       dpWrite;
        logic [7:0]                 dpAddr;
        logic [31:0]                hrdata;
        logic                       hreadyout;
        logic                       hresp;
        logic                       modGreenLed;
        logic                       modRedLed;
        logic                       stateLed;
        logic                       errLed;
        logic                       irq;
    } dlpe_state_t;

    dlpe_state_t st;
    dlpe_state_t next_st;

    logic tick;
    logic blink1;
    logic blink2;
    logic blink4;
    logic flash1;
    logic flash2;
    logic actActive;
    logic pdTelegram;

    // one timebase feeds every lamp so patterns share phase
    dlpe_timebase #(
        .TICK_CYC (TICK_CYC)
    ) u_timebase (
        .clk    (clk),
        .rst_n  (rst_n),
        .tick   (tick),
        .blink1 (blink1),
        .blink2 (blink2),
        .blink4 (blink4),
        .flash1 (flash1),
        .flash2 (flash2)
    );

    // service data telegrams never refresh the activity window
    assign pdTelegram = telegramRx && !telegramSdo;

    dlpe_act_mon u_act_mon (
        .clk      (clk),
        .rst_n    (rst_n),
        .tick     (tick),
        .telegram (pdTelegram),
        .active   (actActive)
    );

    // grouped module and system bus conditions
    logic modDark;
    logic redOnCond;
    logic flash2Cond;
    logic flash1Cond;
    logic redBlinkCond;
    logic errOnCond;
    logic err4Cond;
    logic err1Cond;

    assign modDark      = !modReady || !ctrlVoltOk || !modFitted ||
                          modIsIoExt;
    assign redOnCond    = cfgError || modBusOff;
    assign flash2Cond   = wdTimeout || dipInvalid;
    assign flash1Cond   = extTimeout;
    assign redBlinkCond = ctrlInaccess || modWarning || busIfErr;
    assign errOnCond    = sysBusOff;
    assign err4Cond     = tgTimeout || extMonTimeout;
    assign err1Cond     = extBusTimeout || extModuleErr;

    // turns a pattern into the lamp level for this cycle
    function automatic logic patLevel(dlpe_pkg::dlpe_pat_t p);
        logic lvl;
        lvl = 1'b0;
        unique case (p)
            dlpe_pkg::PAT_OFF:    lvl = 1'b0;
            dlpe_pkg::PAT_ON:     lvl = 1'b1;
            dlpe_pkg::PAT_BLINK1: lvl = blink1;
            dlpe_pkg::PAT_BLINK2: lvl = blink2;
            dlpe_pkg::PAT_BLINK4: lvl = blink4;
            dlpe_pkg::PAT_FLASH1: lvl = flash1;
            dlpe_pkg::PAT_FLASH2: lvl = flash2;
            default:              lvl = 1'b0;
        endcase
        return lvl;
    endfunction

    logic                       addrPhase;
    logic                       hitWrite;
    logic                       modLvl;
    logic [dlpe_pkg::IRQ_W-1:0] events;
    logic [dlpe_pkg::IRQ_W-1:0] w1c;
    logic                       modFaultNow;

    assign addrPhase = hsel && htrans[1] && hready;
    assign hitWrite  = st.dpValid && st.dpWrite;

    // lamp selection, status word, registers and bus answer
    always_comb begin
        next_st = st;
        events  = '0;
        w1c     = '0;

        // module lamp: dark beats all, then severity order
        next_st.modRed = 1'b0;
        if (modDark) begin
            next_st.modPat = dlpe_pkg::PAT_OFF;
        end else if (redOnCond) begin
            next_st.modPat = dlpe_pkg::PAT_ON;
            next_st.modRed = 1'b1;
        end else if (flash2Cond) begin
            next_st.modPat = dlpe_pkg::PAT_FLASH2;
            next_st.modRed = 1'b1;
        end else if (flash1Cond) begin
            next_st.modPat = dlpe_pkg::PAT_FLASH1;
            next_st.modRed = 1'b1;
        end else if (redBlinkCond) begin
            next_st.modPat = dlpe_pkg::PAT_BLINK2;
            next_st.modRed = 1'b1;
        end else if (cyclicRun) begin
            next_st.modPat = dlpe_pkg::PAT_ON;
        end else if (modInit) begin
            next_st.modPat = dlpe_pkg::PAT_BLINK2;
        end else begin
            next_st.modPat = dlpe_pkg::PAT_OFF;
        end

        // status word mirrors every present module condition except init during cyclic exchange
        next_st.msw = '0;
        if (!modDark) begin
            next_st.msw[dlpe_pkg::MSW_INIT]     = modInit && !cyclicRun;
            next_st.msw[dlpe_pkg::MSW_CYCLIC]   = cyclicRun;
            next_st.msw[dlpe_pkg::MSW_RED_BLNK] = redBlinkCond;
            next_st.msw[dlpe_pkg::MSW_RED_ON]   = redOnCond;
            if (st.ctrlFc) begin
                next_st.msw[dlpe_pkg::MSW_FC_FLASH] =
                    flash1Cond || flash2Cond;
            end else begin
                next_st.msw[dlpe_pkg::MSW_FLASH1] = flash1Cond;
                next_st.msw[dlpe_pkg::MSW_FLASH2] = flash2Cond;
            end
        end

        // state lamp: a pending warning outranks plain activity
        if (sysWarning) begin
            next_st.statePat = dlpe_pkg::PAT_BLINK4;
        end else if (actActive) begin
            next_st.statePat = dlpe_pkg::PAT_ON;
        end else begin
            next_st.statePat = dlpe_pkg::PAT_OFF;
        end

        // error lamp: bus off, then timeouts, then external errors
        if (errOnCond) begin
            next_st.errPat = dlpe_pkg::PAT_ON;
        end else if (err4Cond) begin
            next_st.errPat = dlpe_pkg::PAT_BLINK4;
        end else if (err1Cond) begin
            next_st.errPat = dlpe_pkg::PAT_BLINK1;
        end else begin
            next_st.errPat = dlpe_pkg::PAT_OFF;
        end

        // lamp levels follow the registered patterns one cycle later
        modLvl              = patLevel(st.modPat);
        next_st.modGreenLed = modLvl && !st.modRed;
        next_st.modRedLed   = modLvl && st.modRed;
        next_st.stateLed    = patLevel(st.statePat);
        next_st.errLed      = patLevel(st.errPat);

        // interrupt events on rising fault and on loss of activity
        modFaultNow                  = !modDark && (redOnCond ||
                                       flash2Cond || flash1Cond ||
                                       redBlinkCond);
        events[dlpe_pkg::IRQ_MOD_FAULT] = modFaultNow && !st.modRed;
        events[dlpe_pkg::IRQ_ACT_LOST]  = st.prevActive && !actActive;
        events[dlpe_pkg::IRQ_SYS_ERR]   = (errOnCond || err4Cond ||
                                           err1Cond) &&
                                          st.errPat == dlpe_pkg::PAT_OFF;
        events[dlpe_pkg::IRQ_BUS_OFF]   = errOnCond &&
                                          st.errPat != dlpe_pkg::PAT_ON;
        next_st.prevActive = actActive;

        // data phase write; a one clears a status bit
        if (hitWrite) begin
            unique case (st.dpAddr)
                dlpe_pkg::REG_CTRL:
                    next_st.ctrlFc = hwdata[dlpe_pkg::CTRL_FC_VARIANT];
                dlpe_pkg::REG_IRQ_STAT:
                    w1c = hwdata[dlpe_pkg::IRQ_W-1:0];
                dlpe_pkg::REG_IRQ_MASK:
                    next_st.irqMask = hwdata[dlpe_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
        // a new event wins over a clear in the same cycle
        next_st.irqStat = (st.irqStat & ~w1c) | events;
        next_st.irq     = |(next_st.irqStat & next_st.irqMask);

        // address phase; writable register read data is taken from next values so a
        // read right behind a write sees the written value
        next_st.dpValid   = addrPhase;
        next_st.dpWrite   = hwrite;
        next_st.dpAddr    = haddr[7:0];
        next_st.hreadyout = 1'b1;
        next_st.hresp     = 1'b0;
        next_st.hrdata    = '0;
        if (addrPhase && !hwrite && haddr[31:8] == 24'h000000) begin
            unique case (haddr[7:0])
                dlpe_pkg::REG_CTRL:
                    next_st.hrdata[dlpe_pkg::CTRL_FC_VARIANT] =
                        next_st.ctrlFc;
                dlpe_pkg::REG_MSW:
                    next_st.hrdata[dlpe_pkg::MSW_W-1:0] = st.msw;
                dlpe_pkg::REG_LAMP: begin
                    next_st.hrdata[dlpe_pkg::LAMP_MOD_PAT +: 3] = st.modPat;
                    next_st.hrdata[dlpe_pkg::LAMP_MOD_RED]      = st.modRed;
                    next_st.hrdata[dlpe_pkg::LAMP_ST_PAT +: 3]  = st.statePat;
                    next_st.hrdata[dlpe_pkg::LAMP_ERR_PAT +: 3] = st.errPat;
                end
                dlpe_pkg::REG_IRQ_STAT:
                    next_st.hrdata[dlpe_pkg::IRQ_W-1:0] = next_st.irqStat;
                dlpe_pkg::REG_IRQ_MASK:
                    next_st.hrdata[dlpe_pkg::IRQ_W-1:0] = next_st.irqMask;
                default: ;
            endcase
        end
        if (haddr[31:8] != 24'h000000) begin
            next_st.dpWrite = 1'b0; // out of range writes are dropped
        end
    end

    // single register stage for all state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st           <= '0;
            st.ctrlFc    <= dlpe_pkg::CTRL_RST;
            st.irqMask   <= dlpe_pkg::MASK_RST;
            st.modPat    <= dlpe_pkg::PAT_OFF;
            st.statePat  <= dlpe_pkg::PAT_OFF;
            st.errPat    <= dlpe_pkg::PAT_OFF;
            st.hreadyout <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // every output comes straight from the state register
    assign hreadyout   = st.hreadyout;
    assign hrdata      = st.hrdata;
    assign hresp       = st.hresp;
    assign modLedGreen = st.modGreenLed;
    assign modLedRed   = st.modRedLed;
    assign busStateLed = st.stateLed;
    assign busErrLed   = st.errLed;
    assign irq         = st.irq;

    // checks on lamp selection and status word
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_dark_module: assert property (
        modDark [*2] |=> !modLedGreen && !modLedRed)
        else $error("module lamp lit while module dark");
    chk_green_steady: assert property (
        (!modDark && cyclicRun && !modFaultNow) [*2]
        |=> modLedGreen && !modLedRed && st.msw[1])
        else $error("module lamp not steady green during exchange");
    chk_init_blink: assert property (
        (!modDark && modInit && !cyclicRun && !modFaultNow)
        |=> st.modPat == dlpe_pkg::PAT_BLINK2 && !st.modRed &&
            st.msw[0])
        else $error("initialised module not blinking green");
    chk_single_flash: assert property (
        (!modDark && extTimeout && !flash2Cond && !redOnCond &&
         !st.ctrlFc)
        |=> st.modPat == dlpe_pkg::PAT_FLASH1 && st.msw[2])
        else $error("external timeout not shown as single flash");
    chk_double_flash: assert property (
        (!modDark && flash2Cond && !redOnCond)
        |=> st.modPat == dlpe_pkg::PAT_FLASH2 && st.modRed)
        else $error("watchdog fault not shown as double flash");
    chk_variant_bits: assert property (
        (!modDark && st.ctrlFc && $stable(st.ctrlFc) && flash1Cond)
        |=> st.msw[6] && !st.msw[2] && !st.msw[3])
        else $error("variant flash fault in wrong status bit");
    chk_red_blink: assert property (
        (!modDark && redBlinkCond && !redOnCond && !flash2Cond &&
         !flash1Cond)
        |=> st.modPat == dlpe_pkg::PAT_BLINK2 && st.modRed && st.msw[4])
        else $error("module warning not red 2 Hz");
    chk_red_steady: assert property (
        (!modDark && redOnCond) [*2] |=> modLedRed && !modLedGreen)
        else $error("configuration error not steady red");
    chk_state_warn: assert property (
        sysWarning |=> st.statePat == dlpe_pkg::PAT_BLINK4)
        else $error("bus warning not 4 Hz on state lamp");
    chk_state_dark: assert property (
        (!sysWarning && !actActive) [*2] |=> !busStateLed)
        else $error("state lamp lit without activity");
    chk_sdo_ignored: assert property (
        (telegramRx && telegramSdo && !actActive && !tick) |=> !actActive)
        else $error("service data counted as activity");
    chk_err_fast: assert property (
        (err4Cond && !errOnCond)
        |=> st.errPat == dlpe_pkg::PAT_BLINK4)
        else $error("monitoring timeout not 4 Hz red");
    chk_err_slow: assert property (
        (err1Cond && !err4Cond && !errOnCond)
        |=> st.errPat == dlpe_pkg::PAT_BLINK1)
        else $error("external module error not 1 Hz red");
    chk_err_busoff: assert property (
        errOnCond [*2] |=> busErrLed)
        else $error("bus off not steady red");
endmodule

// >>> bench/dlpe_lamp_view.sv
// Purpose: operator view of one lamp, length of its last lit run
// Assumes: lamp is a registered level on clk
// Notes:   runs saturate at 255 clocks; a run counts once the lamp goes dark
`timescale 1ns/100ps
module dlpe_lamp_view (
    // clock
    input  wire logic       clk,
    // lamp under watch and its last lit run in clocks
    input  wire logic       lamp,
    output logic      [7:0] onLen
);
    logic [7:0] run = 8'h0;
    // runs still lit never reach onLen, but a pattern change that darkens the lamp records a short width
    always_ff @(posedge clk) begin
        run   <= lamp ? ((run == 8'hff) ? run : run + 8'h1) : 8'h0;
        onLen <= (!lamp && run != 8'h0) ? run : onLen;
    end
endmodule

// >>> bench/dlpe_encoder_test.sv
// Purpose: self-checking bench for the lamp encoder
// Assumes: tick shortened to TK clocks
// Notes:   registers reached by single word AHB-Lite transfers
`timescale 1ns/100ps
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module dlpe_encoder_test;
    localparam int TK = 10;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, q;
    logic [13:0] mi = 14'h0;
    logic [7:0]  si = 8'h0;
    logic [7:0]  redOn, errOn;
    logic        hreadyout, hresp, irq;
    logic        modLedGreen, modLedRed, busStateLed, busErrLed;
    int          miscompares = 0;
    int          nCompared = 0;
    // expected module lamp codes and status word per single status input
    dlpe_pkg::dlpe_pat_t mp [4:13] = '{dlpe_pkg::PAT_BLINK2, dlpe_pkg::PAT_ON,
        dlpe_pkg::PAT_FLASH1, dlpe_pkg::PAT_FLASH2, dlpe_pkg::PAT_FLASH2,
        dlpe_pkg::PAT_BLINK2, dlpe_pkg::PAT_BLINK2, dlpe_pkg::PAT_BLINK2,
        dlpe_pkg::PAT_ON, dlpe_pkg::PAT_ON};
    logic [6:0] mw [4:13] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h08,
        7'h10, 7'h10, 7'h10, 7'h20, 7'h20};
    dlpe_pkg::dlpe_pat_t ep [3:7] = '{dlpe_pkg::PAT_BLINK4,
        dlpe_pkg::PAT_BLINK4, dlpe_pkg::PAT_BLINK1, dlpe_pkg::PAT_BLINK1,
        dlpe_pkg::PAT_ON};
    // device and the operator watching two of its lamps
    dlpe_encoder #(.TICK_CYC(TK)) uut (.clk(clk), .rst_n(rst_n),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .modReady(mi[0]), .ctrlVoltOk(mi[1]), .modFitted(mi[2]),
        .modIsIoExt(mi[3]), .modInit(mi[4]), .cyclicRun(mi[5]),
        .extTimeout(mi[6]), .wdTimeout(mi[7]), .dipInvalid(mi[8]),
        .ctrlInaccess(mi[9]), .modWarning(mi[10]), .busIfErr(mi[11]),
        .cfgError(mi[12]), .modBusOff(mi[13]), .sysWarning(si[0]),
        .telegramRx(si[1]), .telegramSdo(si[2]), .tgTimeout(si[3]),
        .extMonTimeout(si[4]), .extBusTimeout(si[5]),
        .extModuleErr(si[6]), .sysBusOff(si[7]),
        .modLedGreen(modLedGreen), .modLedRed(modLedRed),
        .busStateLed(busStateLed), .busErrLed(busErrLed), .irq(irq));
    dlpe_lamp_view pr (.clk(clk), .lamp(modLedRed), .onLen(redOn));
    dlpe_lamp_view pe (.clk(clk), .lamp(busErrLed), .onLen(errOn));
    // 200 MHz clock
    always #2.5 clk = ~clk;
    task automatic finalReport;
        $display("compared %0d, mismatches %0d", nCompared, miscompares);
        if (miscompares == 0 && nCompared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // the master never assumes a latency; a stuck bus ends the run
    task automatic waitRdy;
        for (int i = 0; i < 50; i++) begin
            @(posedge clk);
            if (hreadyout === 1'b1) return;
        end
        miscompares++;
        finalReport;
    endtask
    task automatic xfer(input logic w, input logic [31:0] a,
                        input logic [31:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'h2;
        waitRdy;
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= d;
        waitRdy;
        q = hrdata;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] m, e);
        xfer(1'b0, a, 32'h0);
        `CHK(q & m, e)
        `CHK(hresp, 1'b0)
    endtask
    // telegramRx is dropped after one cycle so it stays a pulse
    task automatic put(input logic [13:0] m, input logic [7:0] s);
        @(posedge clk);
        mi <= m;
        si <= s;
        @(posedge clk);
        si[1] <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        `CHK({modLedGreen, modLedRed, busStateLed, busErrLed, irq}, 5'h0)
        rd(dlpe_pkg::REG_CTRL, 32'h1, 32'(dlpe_pkg::CTRL_RST));
        rd(dlpe_pkg::REG_IRQ_MASK, 32'hf, 32'(dlpe_pkg::MASK_RST));
        rd(32'h100, 32'hffffffff, 32'h0);
        $display("test reset and map done");
        for (int i = 4; i < 14; i++) begin
            put(14'h7 | (14'h1 << i), 8'h0);
            rd(dlpe_pkg::REG_LAMP, 32'h7, 32'(mp[i]));
            rd(dlpe_pkg::REG_MSW, 32'h7f, 32'(mw[i]));
        end
        put(14'h1006, 8'h0);
        rd(dlpe_pkg::REG_LAMP, 32'hf, 32'h0);
        rd(dlpe_pkg::REG_MSW, 32'h7f, 32'h0);
        put(14'h002f, 8'h0);
        rd(dlpe_pkg::REG_LAMP, 32'hf, 32'h0);
        put(14'h0027, 8'h0);
        `CHK({modLedGreen, modLedRed}, 2'h2)
        put(14'h1087, 8'h0);
        `CHK({modLedGreen, modLedRed}, 2'h1)
        rd(dlpe_pkg::REG_LAMP, 32'hf, 32'(dlpe_pkg::PAT_ON) | 32'h8);
        put(14'h0047, 8'h0);
        repeat (450) @(posedge clk);
        `CHK(redOn, 8'(2 * TK))
        xfer(1'b1, dlpe_pkg::REG_CTRL, 32'h1);
        rd(dlpe_pkg::REG_MSW, 32'h7f, 32'h40);
        xfer(1'b1, dlpe_pkg::REG_CTRL, 32'h0);
        $display("test module lamp done");
        rd(dlpe_pkg::REG_IRQ_STAT, 32'h1, 32'h1);
        xfer(1'b1, dlpe_pkg::REG_IRQ_MASK, 32'h1);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b1)
        put(14'h7, 8'h0);
        xfer(1'b1, dlpe_pkg::REG_IRQ_STAT, 32'hf);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        $display("test interrupt done");
        for (int i = 3; i < 8; i++) begin
            put(14'h0, 8'h1 << i);
            rd(dlpe_pkg::REG_LAMP, 32'h700, 32'(ep[i]) << 8);
        end
        put(14'h0, 8'h88);
        rd(dlpe_pkg::REG_LAMP, 32'h700, 32'(dlpe_pkg::PAT_ON) << 8);
        put(14'h0, 8'h40);
        repeat (200) @(posedge clk);
        `CHK(errOn, 8'(4 * TK))
        put(14'h0, 8'h08);
        repeat (100) @(posedge clk);
        `CHK(errOn, 8'(TK))
        put(14'h0, 8'h1);
        rd(dlpe_pkg::REG_LAMP, 32'h70, 32'(dlpe_pkg::PAT_BLINK4) << 4);
        put(14'h0, 8'h6);
        `CHK(busStateLed, 1'b0)
        put(14'h0, 8'h2);
        `CHK(busStateLed, 1'b1)
        repeat (5 * TK) @(posedge clk);
        rd(dlpe_pkg::REG_LAMP, 32'h70, 32'(dlpe_pkg::PAT_ON) << 4);
        repeat (4 * TK) @(posedge clk);
        rd(dlpe_pkg::REG_LAMP, 32'h70, 32'h0);
        $display("test system bus lamps done");
        finalReport;
    end
endmodule
